// >>> verilog/door_check_params.svh
// Constants for the door circuit separated check block.
`ifndef DOOR_CHECK_PARAMS_SVH
`define DOOR_CHECK_PARAMS_SVH
`define FAULT_NONE 8'h00
`define FAULT_MISMATCH 8'h1a
`define FAULT_WIRING 8'h3e
`define MISMATCH_TIME_MS 3000
`define CLK_PERIOD_NS 8
`define MISMATCH_CYCLES (32'((`MISMATCH_TIME_MS * 64'd1000000) / `CLK_PERIOD_NS))
`endif

// >>> verilog/door_check_pkg.sv
// Types for the door circuit separated check block.
package door_check_pkg;
   typedef enum logic [1:0] {
      MODE_TRADITIONAL,
      MODE_SEPARATED,
      MODE_NO_CONTACTOR,
      MODE_INVALID
   } check_mode_t;
endpackage : door_check_pkg

// >>> verilog/mismatch_timer.sv
// Timer that fires after an uninterrupted disagreement of a set length.
module mismatch_timer #(
   parameter int unsigned CYCLES = 375000000
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic differ,
   output logic expired
);
   logic [31:0] count_q;

   // Agreement restarts the count, so only a continuous disagreement expires.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= 32'h0;
      end
      else if (!differ)
      begin
         count_q <= 32'h0;
      end
      else if (count_q != CYCLES[31:0])
      begin
         count_q <= count_q + 32'h1;
      end
   end

   assign expired = differ && (count_q == CYCLES[31:0]);

   restart_on_agree_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !differ |=> count_q == 32'h0) else $error("timer not restarted");
endmodule : mismatch_timer

// >>> verilog/door_circuit_check.sv
// Door circuit separated check: mode selection, mismatch and wiring faults.
`include "door_check_params.svh"
module door_circuit_check
   import door_check_pkg::*;
#(
   parameter int unsigned MISMATCH_CYCLES = `MISMATCH_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hall_door_check_enable,
   input wire logic contactor_absent_select,
   input wire logic cfg_load,
   input wire logic interlock_contactor_feedback,
   input wire logic door_loop_sense_input,
   input wire logic hall_door_sense_input,
   input wire logic relevel_or_advance_open,
   input wire logic fault_clear,
   output logic run_permit,
   output logic [7:0] fault_code,
   output logic fault_active,
   output logic cfg_error
);
   logic hall_en_q;
   logic no_contactor_q;
   check_mode_t mode;
   logic hall_used;
   logic differ;
   logic expired;
   logic wiring_err;
   logic [7:0] fault_q;
   logic permit_q;
   logic cfg_err_q;

   // Selections are latched on cfg_load; an illegal pair is refused.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hall_en_q <= 1'b0;
         no_contactor_q <= 1'b0;
         cfg_err_q <= 1'b0;
      end
      else if (cfg_load)
      begin
         if (contactor_absent_select && !hall_door_check_enable)
         begin
            cfg_err_q <= 1'b1;
         end
         else
         begin
            hall_en_q <= hall_door_check_enable;
            no_contactor_q <= contactor_absent_select;
            cfg_err_q <= 1'b0;
         end
      end
   end

   always_comb
   begin
      if (!hall_en_q)
      begin
         mode = MODE_TRADITIONAL;
      end
      else if (!no_contactor_q)
      begin
         mode = MODE_SEPARATED;
      end
      else
      begin
         mode = MODE_NO_CONTACTOR;
      end
   end

   assign hall_used = !relevel_or_advance_open;

   always_comb
   begin
      differ = 1'b0;
      wiring_err = 1'b0;
      case (mode)
         MODE_TRADITIONAL:
         begin
            differ = interlock_contactor_feedback != door_loop_sense_input;
            wiring_err = hall_door_sense_input;
         end
         MODE_SEPARATED:
         begin
            differ = (interlock_contactor_feedback != door_loop_sense_input) ||
               (hall_used && (hall_door_sense_input != door_loop_sense_input));
         end
         MODE_NO_CONTACTOR:
         begin
            differ = hall_used && (hall_door_sense_input != door_loop_sense_input);
            wiring_err = interlock_contactor_feedback;
         end
         default:
         begin
            differ = 1'b0;
         end
      endcase
   end

   mismatch_timer #(
      .CYCLES(MISMATCH_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .differ(differ),
      .expired(expired)
   );

   // A new fault wins over a clear in the same cycle; wiring faults take priority.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_q <= `FAULT_NONE;
      end
      else if (wiring_err)
      begin
         fault_q <= `FAULT_WIRING;
      end
      else if (expired && mode != MODE_TRADITIONAL)
      begin
         fault_q <= `FAULT_MISMATCH;
      end
      else if (fault_clear)
      begin
         fault_q <= `FAULT_NONE;
      end
   end

   // Running needs every used indication closed and agreeing, with no fault.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         permit_q <= 1'b0;
      end
      else
      begin
         case (mode)
            MODE_TRADITIONAL:
            begin
               permit_q <= interlock_contactor_feedback && door_loop_sense_input &&
                  !wiring_err && fault_q == `FAULT_NONE;
            end
            default:
            begin
               permit_q <= door_loop_sense_input && !differ && !wiring_err &&
                  (hall_door_sense_input || !hall_used) &&
                  fault_q == `FAULT_NONE;
            end
         endcase
      end
   end

   assign run_permit = permit_q;
   assign fault_code = fault_q;
   assign fault_active = fault_q != `FAULT_NONE;
   assign cfg_error = cfg_err_q;


   // Fault, permit and config checks look one edge ahead of their cause; the differ checks hold in the same cycle.
   wiring_fault_trad_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_TRADITIONAL && hall_door_sense_input |=> fault_q == `FAULT_WIRING)
      else $error("no wiring fault in traditional mode");
   wiring_fault_nocon_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_NO_CONTACTOR && interlock_contactor_feedback |=> fault_q == `FAULT_WIRING)
      else $error("no wiring fault without contactor");
   mismatch_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
      expired && !wiring_err && mode != MODE_TRADITIONAL |=> fault_q == `FAULT_MISMATCH)
      else $error("mismatch fault missing");
   wiring_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wiring_err && expired |=> fault_q == `FAULT_WIRING)
      else $error("wiring fault lost to mismatch");
   trad_no_mismatch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_TRADITIONAL && !wiring_err && fault_q == `FAULT_NONE |=> fault_q == `FAULT_NONE)
      else $error("fault raised in traditional mode");
   nocon_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_NO_CONTACTOR && hall_used && hall_door_sense_input != door_loop_sense_input
      |-> differ) else $error("loop and hall difference missed");
   sep_hall_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_SEPARATED && hall_used && hall_door_sense_input != interlock_contactor_feedback
      |-> differ) else $error("hall and contactor difference missed");
   run_needs_loop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !door_loop_sense_input |=> !run_permit)
      else $error("run with door loop open");
   fault_blocks_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
      fault_q != `FAULT_NONE |=> !run_permit)
      else $error("run with a fault standing");
   cfg_accept_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_load && !(contactor_absent_select && !hall_door_check_enable) |=>
      hall_en_q == $past(hall_door_check_enable) && no_contactor_q == $past(contactor_absent_select))
      else $error("legal config not taken");
   hall_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_NO_CONTACTOR && relevel_or_advance_open |-> !differ)
      else $error("hall sense not ignored");
   run_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode != MODE_TRADITIONAL && hall_used && hall_door_sense_input != door_loop_sense_input
      |=> !run_permit) else $error("run with hall and loop differing");
   illegal_cfg_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_load && contactor_absent_select && !hall_door_check_enable
      |=> cfg_error && $stable(no_contactor_q)) else $error("illegal config taken");
   trad_ignores_hall_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_TRADITIONAL |-> differ == (interlock_contactor_feedback
      != door_loop_sense_input)) else $error("hall used in traditional");
   sep_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mode == MODE_SEPARATED && interlock_contactor_feedback != door_loop_sense_input
      |-> differ) else $error("pair difference missed");
endmodule : door_circuit_check

// >>> verification/door_contacts.sv
// Model of the door contacts and the contactor feedback switch.
module door_contacts (
   input wire logic hall_closed,
   input wire logic car_closed,
   input wire logic shorted,
   input wire logic fitted,
   input wire logic stray,
   output logic feedback,
   output logic loop,
   output logic hall
);
   timeunit 1ns;
   timeprecision 1ps;
   // The door loop runs hall and car contacts in series; a jumper bridges both.
   assign loop = (hall_closed & car_closed) | shorted;
   assign hall = hall_closed;
   // Without a contactor the feedback pin only sees a stray wiring fault.
   assign feedback = fitted ? loop : stray;
endmodule : door_contacts

// >>> verification/tb.sv
// Testbench for the door circuit separated check block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MC = 20;
   logic mclk = 0, rst_n = 0, hce = 0, cas = 0, ld = 0, rlv = 0, clr = 0;
   logic hall_c = 0, car_c = 0, shorted = 0, fitted = 1, stray = 0;
   logic fb, loop, hall, permit, f_act, cfg_err;
   logic [7:0] fault;
   int error_cnt = 0;
   int checks = 0;
   door_contacts door_contacts_i (.hall_closed(hall_c), .car_closed(car_c), .shorted(shorted),
      .fitted(fitted), .stray(stray), .feedback(fb), .loop(loop), .hall(hall));
   door_circuit_check #(.MISMATCH_CYCLES(MC)) door_circuit_check_i (.mclk(mclk), .rst_n(rst_n),
      .hall_door_check_enable(hce), .contactor_absent_select(cas), .cfg_load(ld),
      .interlock_contactor_feedback(fb), .door_loop_sense_input(loop),
      .hall_door_sense_input(hall), .relevel_or_advance_open(rlv), .fault_clear(clr),
      .run_permit(permit), .fault_code(fault), .fault_active(f_act), .cfg_error(cfg_err));
   initial forever #4 mclk = ~mclk;
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic cfg(input logic h, input logic a);
      hce = h;
      cas = a;
      ld = 1;
      cyc(1);
      ld = 0;
      cyc(1);
   endtask : cfg
   task automatic fclr;
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(1);
   endtask : fclr
   task automatic t_trad;
      chk("cfg_error", cfg_err, 8'h00);
      chk("permit", permit, 8'h00);
      hall_c = 1;
      cyc(2);
      chk("fault", fault, 8'h3e);
      chk("fault_active", f_act, 8'h01);
      hall_c = 0;
      car_c = 1;
      shorted = 1;
      fclr();
      cyc(MC + 5);
      chk("fault", fault, 8'h00);
      chk("permit", permit, 8'h01);
      fitted = 0;
      cyc(MC + 5);
      chk("fault", fault, 8'h00);
      chk("permit", permit, 8'h00);
      fitted = 1;
      cfg(0, 1);
      chk("cfg_error", cfg_err, 8'h01);
      $display("test traditional done");
   endtask : t_trad
   task automatic t_sep;
      cfg(1, 0);
      chk("cfg_error", cfg_err, 8'h00);
      hall_c = 1;
      cyc(2);
      chk("permit", permit, 8'h01);
      hall_c = 0;
      cyc(2);
      chk("permit", permit, 8'h00);
      cyc(MC - 6);
      hall_c = 1;
      cyc(1);
      hall_c = 0;
      cyc(MC - 2);
      chk("fault", fault, 8'h00);
      cyc(8);
      chk("fault", fault, 8'h1a);
      hall_c = 1;
      rlv = 1;
      fclr();
      hall_c = 0;
      cyc(MC + 8);
      chk("fault", fault, 8'h00);
      chk("permit", permit, 8'h01);
      fitted = 0;
      cyc(MC + 8);
      chk("fault", fault, 8'h1a);
      chk("permit", permit, 8'h00);
      fitted = 1;
      rlv = 0;
      $display("test separated done");
   endtask : t_sep
   task automatic t_nocon;
      hall_c = 1;
      shorted = 0;
      cfg(1, 1);
      fitted = 0;
      stray = 1;
      cyc(2);
      chk("fault", fault, 8'h3e);
      stray = 0;
      fclr();
      cyc(1);
      chk("permit", permit, 8'h01);
      hall_c = 0;
      shorted = 1;
      cyc(MC + 8);
      chk("fault", fault, 8'h1a);
      chk("permit", permit, 8'h00);
      $display("test no contactor done");
   endtask : t_nocon
   task automatic t_reset;
      rst_n = 0;
      cyc(2);
      chk("fault", fault, 8'h00);
      chk("permit", permit, 8'h00);
      fitted = 1;
      rst_n = 1;
      cyc(2);
      chk("fault", fault, 8'h00);
      chk("permit", permit, 8'h01);
      $display("test mid-run reset done");
   endtask : t_reset
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      cyc(6);
      rst_n = 1;
      cyc(1);
      t_trad();
      t_sep();
      t_nocon();
      t_reset();
      complete_run();
   end
   initial
   begin
      #(8 * 4000);
      error_cnt++;
      complete_run();
   end
endmodule : tb
